// ### audio_pin_mux_consts.vh
`ifndef AUDIO_PIN_MUX_CONSTS_VH
`define AUDIO_PIN_MUX_CONSTS_VH

// ==========================================
// Line and port counts
`define SHARED_LINES 4
`define TX_ONLY_LINES 2
`define ALL_LINES 6
`define PORT_BITS 7
`define TX_SHIFTERS 6

// ==========================================
// Port bit control codes, two bits per port bit
`define PORT_CTRL_W 2
`define PORT_CTRL_OFF 2'h0
`define PORT_CTRL_IN 2'h1
`define PORT_CTRL_OUT 2'h2
`define PORT_CTRL_OUT_ALT 2'h3

// ==========================================
// Synchroniser and buffering
`define SYNC_STAGES 3
`define RX_WORD_W 4
`define RX_FIFO_DEPTH 4
`define RX_FIFO_AW 2

// ==========================================
// Link timing
`define SYS_PERIOD_NS 20
`define LINK_MIN_PERIOD_NS 160
`define LINK_MIN_PERIOD_CYC ((`LINK_MIN_PERIOD_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)

`endif

// ### pin_sync3.v
`timescale 1ns/1ps
// ==========================================
// Three-stage synchroniser; a bit changes once stages two and three agree
module pin_sync3 #(
  parameter W = 1
) (
  input wire i_clk_sys,
  input wire i_arst_n,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_level
);
  reg [W-1:0] stage1_reg;
  reg [W-1:0] stage2_reg;
  reg [W-1:0] stage3_reg;
  integer k;

  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage1_reg <= {W{1'b0}};
      stage2_reg <= {W{1'b0}};
      stage3_reg <= {W{1'b0}};
      o_level <= {W{1'b0}};
    end else begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      for (k = 0; k < W; k = k + 1) begin
        if (stage2_reg[k] == stage3_reg[k]) begin
          o_level[k] <= stage3_reg[k];
        end
      end
    end
  end
endmodule

// ### sample_fifo.v
`timescale 1ns/1ps
// ==========================================
// Small synchronous FIFO with valid/ready on both sides
module sample_fifo #(
  parameter WIDTH = 4,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire i_clk_sys,
  input wire i_arst_n,
  input wire i_wr_valid,
  input wire [WIDTH-1:0] i_wr_data,
  output wire o_wr_ready,
  output wire o_rd_valid,
  output wire [WIDTH-1:0] o_rd_data,
  input wire i_rd_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign o_wr_ready = (count_reg != DEPTH[AW:0]);
  assign o_rd_valid = (count_reg != {(AW+1){1'b0}});
  assign o_rd_data = mem[rptr_reg];
  assign push = i_wr_valid && o_wr_ready;
  assign pop = o_rd_valid && i_rd_ready;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - 1'b1) begin
        ptr_inc = {AW{1'b0}};
      end else begin
        ptr_inc = p + 1'b1;
      end
    end
  endfunction

  always @(posedge i_clk_sys) begin
    if (push) begin
      mem[wptr_reg] <= i_wr_data;
    end
  end

  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_reg <= ptr_inc(wptr_reg);
      end
      if (pop) begin
        rptr_reg <= ptr_inc(rptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ### serial_audio_data_pin_mux.v
`timescale 1ns/1ps
`include "audio_pin_mux_consts.vh"

module serial_audio_data_pin_mux (
  input wire i_clk_sys,
  input wire i_arst_n,
  // Mode and line setup
  input wire i_gpio_mode,
  input wire [`ALL_LINES-1:0] i_line_enable,
  input wire [`SHARED_LINES-1:0] i_line_is_tx,
  // General-purpose port: bit 0 is port bit three, bits 1..6 are port bits six..eleven
  input wire [`PORT_BITS*`PORT_CTRL_W-1:0] i_port_ctrl,
  input wire [`PORT_BITS-1:0] i_port_data_out,
  output reg [`PORT_BITS-1:0] o_port_data_in,
  // Transmit shifter serial outputs, indexed by shifter number
  input wire [`TX_SHIFTERS-1:0] i_transmit_shifter_bits,
  // Receive bit clock from the link
  input wire i_rx_bit_clk,
  // Receive words toward receive shifters zero..three
  output reg o_rx_valid,
  output reg [`RX_WORD_W-1:0] o_rx_bits,
  input wire i_rx_ready,
  output reg o_rx_overrun,
  input wire i_rx_overrun_clr,
  // Port bit three pin
  input wire i_port_bit_three_in,
  output reg o_port_bit_three_out,
  output reg o_port_bit_three_oe,
  // Shared line pins
  input wire i_shared_line_five_zero_in,
  output reg o_shared_line_five_zero_out,
  output reg o_shared_line_five_zero_oe,
  input wire i_shared_line_four_one_in,
  output reg o_shared_line_four_one_out,
  output reg o_shared_line_four_one_oe,
  input wire i_shared_line_three_two_in,
  output reg o_shared_line_three_two_out,
  output reg o_shared_line_three_two_oe,
  input wire i_shared_line_two_three_in,
  output reg o_shared_line_two_three_out,
  output reg o_shared_line_two_three_oe,
  // Transmit-only line pins
  input wire i_transmit_only_line_one_in,
  output reg o_transmit_only_line_one,
  output reg o_transmit_only_line_one_oe,
  input wire i_transmit_only_line_zero_in,
  output reg o_transmit_only_line_zero,
  output reg o_transmit_only_line_zero_oe
);

  // ==========================================
  // Pin input synchronisation
  // Bit clock rides in the same synchroniser as the data so both settle together
  wire [`PORT_BITS:0] pin_raw;
  wire [`PORT_BITS:0] pin_sync;
  wire [`PORT_BITS-1:0] pin_level;
  wire bit_clk_level;
  reg bit_clk_prev_reg;
  wire bit_clk_rise;

  assign pin_raw = {i_rx_bit_clk,
                    i_transmit_only_line_zero_in,
                    i_transmit_only_line_one_in,
                    i_shared_line_two_three_in,
                    i_shared_line_three_two_in,
                    i_shared_line_four_one_in,
                    i_shared_line_five_zero_in,
                    i_port_bit_three_in};

  pin_sync3 #(
    .W(`PORT_BITS + 1)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_async(pin_raw),
    .o_level(pin_sync)
  );

  assign pin_level = pin_sync[`PORT_BITS-1:0];
  assign bit_clk_level = pin_sync[`PORT_BITS];
  assign bit_clk_rise = bit_clk_level && !bit_clk_prev_reg;

  // ==========================================
  // Per-pin drive decisions
  function [1:0] port_ctrl_of;
    input [`PORT_BITS*`PORT_CTRL_W-1:0] ctrl;
    input integer idx;
    begin
      port_ctrl_of = ctrl[idx*`PORT_CTRL_W +: `PORT_CTRL_W];
    end
  endfunction

  function port_drives;
    input [1:0] code;
    begin
      port_drives = (code == `PORT_CTRL_OUT) || (code == `PORT_CTRL_OUT_ALT);
    end
  endfunction

  // Transmit shifter that feeds each line: lines 0..5 take shifters 5..0
  function [2:0] tx_index_of_line;
    input integer line;
    begin
      tx_index_of_line = 3'h5 - line[2:0];
    end
  endfunction

  reg [`PORT_BITS-1:0] out_next;
  reg [`PORT_BITS-1:0] oe_next;
  reg [`PORT_BITS-1:0] gpio_sample_en;
  reg [`SHARED_LINES-1:0] rx_enable;
  integer n;

  always @* begin
    out_next = {`PORT_BITS{1'b0}};
    oe_next = {`PORT_BITS{1'b0}};
    gpio_sample_en = {`PORT_BITS{1'b0}};
    rx_enable = {`SHARED_LINES{1'b0}};
    if (i_gpio_mode) begin
      for (n = 0; n < `PORT_BITS; n = n + 1) begin
        // Output only when programmed so; off and input never drive
        oe_next[n] = port_drives(port_ctrl_of(i_port_ctrl, n));
        out_next[n] = oe_next[n] && i_port_data_out[n];
        gpio_sample_en[n] = (port_ctrl_of(i_port_ctrl, n) == `PORT_CTRL_IN);
      end
    end else begin
      // Port bit three belongs to another serial function here; keep it quiet
      for (n = 0; n < `SHARED_LINES; n = n + 1) begin
        if (i_line_enable[n] && i_line_is_tx[n]) begin
          oe_next[n+1] = 1'b1;
          out_next[n+1] = i_transmit_shifter_bits[tx_index_of_line(n)];
        end else if (i_line_enable[n]) begin
          rx_enable[n] = 1'b1;
        end
      end
      for (n = `SHARED_LINES; n < `ALL_LINES; n = n + 1) begin
        if (i_line_enable[n]) begin
          oe_next[n+1] = 1'b1;
          out_next[n+1] = i_transmit_shifter_bits[tx_index_of_line(n)];
        end
      end
    end
  end

  // ==========================================
  // Registered pin drive; reset leaves every line disconnected
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_port_bit_three_out <= 1'b0;
      o_port_bit_three_oe <= 1'b0;
      o_shared_line_five_zero_out <= 1'b0;
      o_shared_line_five_zero_oe <= 1'b0;
      o_shared_line_four_one_out <= 1'b0;
      o_shared_line_four_one_oe <= 1'b0;
      o_shared_line_three_two_out <= 1'b0;
      o_shared_line_three_two_oe <= 1'b0;
      o_shared_line_two_three_out <= 1'b0;
      o_shared_line_two_three_oe <= 1'b0;
      o_transmit_only_line_one <= 1'b0;
      o_transmit_only_line_one_oe <= 1'b0;
      o_transmit_only_line_zero <= 1'b0;
      o_transmit_only_line_zero_oe <= 1'b0;
      o_port_data_in <= {`PORT_BITS{1'b0}};
    end else begin
      o_port_bit_three_out <= out_next[0];
      o_port_bit_three_oe <= oe_next[0];
      o_shared_line_five_zero_out <= out_next[1];
      o_shared_line_five_zero_oe <= oe_next[1];
      o_shared_line_four_one_out <= out_next[2];
      o_shared_line_four_one_oe <= oe_next[2];
      o_shared_line_three_two_out <= out_next[3];
      o_shared_line_three_two_oe <= oe_next[3];
      o_shared_line_two_three_out <= out_next[4];
      o_shared_line_two_three_oe <= oe_next[4];
      o_transmit_only_line_one <= out_next[5];
      o_transmit_only_line_one_oe <= oe_next[5];
      o_transmit_only_line_zero <= out_next[6];
      o_transmit_only_line_zero_oe <= oe_next[6];
      // Disconnected and output bits read as zero, not the pin
      o_port_data_in <= pin_level & gpio_sample_en;
    end
  end

  // ==========================================
  // Receive capture on each bit clock rising edge while a shared line is enabled for receive
  // Word bit k goes to receive shifter k; shared line k feeds shifter k
  wire [`RX_WORD_W-1:0] rx_capture;
  wire cap_valid;
  wire fifo_wr_ready;
  wire fifo_rd_valid;
  wire [`RX_WORD_W-1:0] fifo_rd_data;
  wire fifo_pop;

  assign rx_capture = pin_level[`SHARED_LINES:1] & rx_enable;
  assign cap_valid = bit_clk_rise && (|rx_enable);
  assign fifo_pop = fifo_rd_valid && (!o_rx_valid || i_rx_ready);

  sample_fifo #(
    .WIDTH(`RX_WORD_W),
    .DEPTH(`RX_FIFO_DEPTH),
    .AW(`RX_FIFO_AW)
  ) u_rx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_wr_valid(cap_valid),
    .i_wr_data(rx_capture),
    .o_wr_ready(fifo_wr_ready),
    .o_rd_valid(fifo_rd_valid),
    .o_rd_data(fifo_rd_data),
    .i_rd_ready(fifo_pop)
  );

  // Bit clock cannot be stalled, so a capture into a full FIFO is lost and flagged
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_clk_prev_reg <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_bits <= {`RX_WORD_W{1'b0}};
      o_rx_overrun <= 1'b0;
    end else begin
      bit_clk_prev_reg <= bit_clk_level;
      if (fifo_pop) begin
        o_rx_valid <= 1'b1;
        o_rx_bits <= fifo_rd_data;
      end else if (i_rx_ready) begin
        o_rx_valid <= 1'b0;
      end
      // Set wins over clear
      if (cap_valid && !fifo_wr_ready) begin
        o_rx_overrun <= 1'b1;
      end else if (i_rx_overrun_clr) begin
        o_rx_overrun <= 1'b0;
      end
    end
  end
endmodule

// ### pin_mux_props.sv
`timescale 1ns/1ps
// ==========================================
// Pin drive and receive checks
module pin_mux_props (
  input wire i_clk_sys,
  input wire i_arst_n,
  input wire i_gpio_mode,
  input wire [5:0] i_line_enable,
  input wire [3:0] i_line_is_tx,
  input wire [13:0] i_port_ctrl,
  input wire [6:0] i_port_data_out,
  input wire [5:0] i_transmit_shifter_bits,
  input wire o_rx_valid,
  input wire [3:0] o_rx_bits,
  input wire i_rx_ready,
  input wire o_port_bit_three_oe,
  input wire o_shared_line_five_zero_out,
  input wire o_shared_line_five_zero_oe,
  input wire o_shared_line_four_one_out,
  input wire o_shared_line_four_one_oe,
  input wire o_shared_line_three_two_out,
  input wire o_shared_line_three_two_oe,
  input wire o_shared_line_two_three_out,
  input wire o_shared_line_two_three_oe,
  input wire o_transmit_only_line_one,
  input wire o_transmit_only_line_one_oe,
  input wire o_transmit_only_line_zero,
  input wire o_transmit_only_line_zero_oe
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  reg [1:0] live_reg;
  wire [5:0] loe = {o_transmit_only_line_zero_oe, o_transmit_only_line_one_oe, o_shared_line_two_three_oe,
    o_shared_line_three_two_oe, o_shared_line_four_one_oe, o_shared_line_five_zero_oe};
  wire [5:0] lout = {o_transmit_only_line_zero, o_transmit_only_line_one, o_shared_line_two_three_out,
    o_shared_line_three_two_out, o_shared_line_four_one_out, o_shared_line_five_zero_out};
  wire [5:0] drv = i_line_enable & {2'h3, i_line_is_tx};
  wire [5:0] sh = i_transmit_shifter_bits;
  wire [6:0] pdir = {i_port_ctrl[13], i_port_ctrl[11], i_port_ctrl[9], i_port_ctrl[7], i_port_ctrl[5],
    i_port_ctrl[3], i_port_ctrl[1]};
  wire s = !i_gpio_mode;
  // Outputs are judged only once a full cycle of inputs has been seen after reset
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) live_reg <= 2'h0;
    else live_reg <= {live_reg[0], 1'b1};
  end
  chk_five_zero_tx: assert property (
    live_reg[1] && $past(s && drv[0]) |-> loe[0] && lout[0] == $past(sh[5])) else $error("line five zero");
  chk_four_one_tx: assert property (
    live_reg[1] && $past(s && drv[1]) |-> loe[1] && lout[1] == $past(sh[4])) else $error("line four one");
  chk_three_two_tx: assert property (
    live_reg[1] && $past(s && drv[2]) |-> loe[2] && lout[2] == $past(sh[3])) else $error("line three two");
  chk_two_three_tx: assert property (
    live_reg[1] && $past(s && drv[3]) |-> loe[3] && lout[3] == $past(sh[2])) else $error("line two three");
  chk_tx_one_line: assert property (
    live_reg[1] && $past(s && drv[4]) |-> loe[4] && lout[4] == $past(sh[1])) else $error("tx only one");
  chk_tx_zero_line: assert property (
    live_reg[1] && $past(s && drv[5]) |-> loe[5] && lout[5] == $past(sh[0])) else $error("tx only zero");
  chk_serial_no_drive: assert property (
    live_reg[1] && $past(s) |-> loe == $past(drv) && !o_port_bit_three_oe) else $error("stray drive");
  chk_gpio_dir: assert property (
    live_reg[1] && $past(i_gpio_mode) |-> {loe, o_port_bit_three_oe} == $past(pdir)) else $error("port dir");
  chk_gpio_value: assert property (
    live_reg[1] && $past(!s && i_port_ctrl[3]) |-> lout[0] == $past(i_port_data_out[1])) else $error("port out");
  chk_reset_quiet: assert property (
    disable iff (1'b0) !i_arst_n |-> !o_port_bit_three_oe && loe == 6'h00) else $error("drive in reset");
  chk_rx_hold: assert property (
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_bits)) else $error("rx word dropped");
  cov_rx_taken: cover property (o_rx_valid && i_rx_ready);
  cov_tx_drive: cover property (s && loe == 6'h3F);
  cov_gpio_out: cover property (i_gpio_mode && o_port_bit_three_oe);
endmodule
bind serial_audio_data_pin_mux pin_mux_props props (.*);

// ### codec_model.sv
`timescale 1ns/1ps
// ==========================================
// External codec on the data lines; bit clock runs only within a word
module codec_model (
  input wire [6:0] i_oe,
  input wire [6:0] i_out,
  output wire [6:0] o_level,
  output reg o_bit_clk,
  output reg o_clash
);
  reg [6:0] drv_en_reg = 7'h00;
  reg [6:0] drv_reg = 7'h00;
  // Released lines fall to the pad pull-downs
  assign o_level = (i_oe & i_out) | (~i_oe & drv_en_reg & drv_reg);
  always @* o_clash = |(i_oe & drv_en_reg);
  initial o_bit_clk = 1'b0;
  task set_lines(input [6:0] en, input [6:0] d);
    drv_en_reg = en;
    drv_reg = d;
  endtask
  task send(input [6:0] en, input [6:0] d);
    set_lines(en, d);
    #40 o_bit_clk = 1'b1;
    #80 o_bit_clk = 1'b0;
    #40 set_lines(7'h00, 7'h00);
  endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  reg i_clk_sys = 1'b0;
  reg i_arst_n = 1'b1;
  reg i_gpio_mode = 1'b1;
  reg [5:0] i_line_enable = 6'h00;
  reg [3:0] i_line_is_tx = 4'h0;
  reg [13:0] i_port_ctrl = 14'h0000;
  reg [6:0] i_port_data_out = 7'h00;
  reg [5:0] i_transmit_shifter_bits = 6'h00;
  reg i_rx_ready = 1'b0;
  reg i_rx_overrun_clr = 1'b0;
  wire [6:0] oe, out, lvl, o_port_data_in;
  wire [3:0] o_rx_bits;
  wire o_rx_valid, o_rx_overrun, bit_clk, clash;
  integer miscompares = 0;
  integer total_checks = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  codec_model codec (.i_oe(oe), .i_out(out), .o_level(lvl), .o_bit_clk(bit_clk), .o_clash(clash));
  serial_audio_data_pin_mux uut (.i_clk_sys, .i_arst_n, .i_gpio_mode, .i_line_enable, .i_line_is_tx,
    .i_port_ctrl, .i_port_data_out, .o_port_data_in, .i_transmit_shifter_bits, .i_rx_bit_clk(bit_clk),
    .o_rx_valid, .o_rx_bits, .i_rx_ready, .o_rx_overrun, .i_rx_overrun_clr,
    .i_port_bit_three_in(lvl[0]), .o_port_bit_three_out(out[0]), .o_port_bit_three_oe(oe[0]),
    .i_shared_line_five_zero_in(lvl[1]), .o_shared_line_five_zero_out(out[1]), .o_shared_line_five_zero_oe(oe[1]),
    .i_shared_line_four_one_in(lvl[2]), .o_shared_line_four_one_out(out[2]), .o_shared_line_four_one_oe(oe[2]),
    .i_shared_line_three_two_in(lvl[3]), .o_shared_line_three_two_out(out[3]), .o_shared_line_three_two_oe(oe[3]),
    .i_shared_line_two_three_in(lvl[4]), .o_shared_line_two_three_out(out[4]), .o_shared_line_two_three_oe(oe[4]),
    .i_transmit_only_line_one_in(lvl[5]), .o_transmit_only_line_one(out[5]), .o_transmit_only_line_one_oe(oe[5]),
    .i_transmit_only_line_zero_in(lvl[6]), .o_transmit_only_line_zero(out[6]),
    .o_transmit_only_line_zero_oe(oe[6]));
  // ==========================================
  // Shared tasks
  task check(input [6:0] seen, input [6:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task take_word(input [3:0] exp);
    integer k;
    for (k = 0; k < 40 && o_rx_valid !== 1'b1; k = k + 1) step(1);
    check({3'h0, o_rx_valid}, 7'h01);
    if (o_rx_valid !== 1'b1) finish_test;
    check({3'h0, o_rx_bits}, {3'h0, exp});
    i_rx_ready = 1'b1;
    step(1);
    i_rx_ready = 1'b0;
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    codec.set_lines(7'h7F, 7'h7F);
    step(8);
    check(oe, 7'h00);
    check(o_port_data_in, 7'h00);
    codec.set_lines(7'h00, 7'h00);
  endtask
  task t_tx;
    integer n;
    reg [5:0] t;
    i_gpio_mode = 1'b0;
    i_line_enable = 6'h3F;
    i_line_is_tx = 4'hF;
    for (n = 0; n < 7; n = n + 1) begin
      t = (n < 6) ? (6'h01 << n) : 6'h2D;
      i_transmit_shifter_bits = t;
      step(2);
      check(oe, 7'h7E);
      check(out & oe, {t[0], t[1], t[2], t[3], t[4], t[5], 1'b0});
    end
    i_line_enable = 6'h1D;
    i_line_is_tx = 4'h5;
    step(2);
    check(oe, 7'h2A);
  endtask
  task t_rx;
    integer n;
    i_line_is_tx = 4'h0;
    i_line_enable = 6'h0F;
    step(2);
    check(oe, 7'h00);
    for (n = 0; n < 7; n = n + 1) codec.send(7'h1E, {2'h0, n[3:0] + 4'h9, 1'b0});
    step(8);
    check({6'h00, o_rx_overrun}, 7'h01);
    for (n = 0; n < 4; n = n + 1) take_word(n[3:0] + 4'h9);
    i_rx_ready = 1'b1;
    step(20);
    i_rx_ready = 1'b0;
    i_rx_overrun_clr = 1'b1;
    step(1);
    i_rx_overrun_clr = 1'b0;
    step(1);
    check({6'h00, o_rx_overrun}, 7'h00);
    i_line_is_tx = 4'h3;
    step(2);
    codec.send(7'h18, 7'h18);
    take_word(4'hC);
    check({6'h00, clash}, 7'h00);
  endtask
  task t_gpio;
    integer c;
    i_gpio_mode = 1'b1;
    for (c = 2; c < 4; c = c + 1) begin
      i_port_ctrl = {7{c[1:0]}};
      i_port_data_out = (c == 2) ? 7'h55 : 7'h2A;
      step(2);
      check(oe, 7'h7F);
      check(out, i_port_data_out);
    end
    i_port_ctrl = {7{2'h1}};
    // Let the port release its drive before the codec takes the lines
    step(2);
    codec.set_lines(7'h7F, 7'h33);
    step(8);
    check(oe, 7'h00);
    check(o_port_data_in, 7'h33);
    i_port_ctrl = 14'h0000;
    step(8);
    check(o_port_data_in, 7'h00);
    check({6'h00, clash}, 7'h00);
    codec.set_lines(7'h00, 7'h00);
    i_port_ctrl = {7{2'h2}};
    step(2);
    check(oe, 7'h7F);
    // Reset in mid-run must drop every drive by the next clock edge
    i_arst_n = 1'b0;
    step(1);
    check(oe, 7'h00);
    check(o_port_data_in, 7'h00);
    i_arst_n = 1'b1;
    step(2);
    check(oe, 7'h7F);
  endtask
  initial begin
    // Real falling edge so the design's flops leave the unknown state before the first clock
    #1 i_arst_n = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    check(oe, 7'h00);
    #1 i_arst_n = 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_gpio;
    finish_test;
  end
endmodule
